/* File: include/sacc_pkg.sv */
// package for the converter control block: register map, fields, reset values, timing
package sacc_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] SACC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SACC_CFG_OFS = 8'h04;
  localparam logic [7:0] SACC_CHSEL_OFS = 8'h08;
  localparam logic [7:0] SACC_PAIR_OFS = 8'h0c;
  localparam logic [7:0] SACC_RESH_OFS = 8'h10;
  localparam logic [7:0] SACC_RESL_OFS = 8'h14;
  localparam logic [7:0] SACC_SAMPLE_OFS = 8'h18;

  // ----------------------------------------
  // control and config register bit positions
  // ----------------------------------------
  localparam int SACC_CTRL_EN_BIT = 7;
  localparam int SACC_CTRL_TM_BIT = 6;
  localparam int SACC_CTRL_DONE_BIT = 5;
  localparam int SACC_CTRL_BUSY_BIT = 4;
  localparam int SACC_CTRL_CM_LSB = 2;
  localparam int SACC_CTRL_LJ_BIT = 0;
  localparam int SACC_CFG_DIV_LSB = 3;
  localparam int SACC_CFG_GAIN_LSB = 0;

  // ----------------------------------------
  // reset values and temperature channel code
  // ----------------------------------------
  localparam logic [7:0] SACC_CTRL_RST = 8'h00;
  localparam logic [7:0] SACC_CFG_RST = 8'hf8;
  localparam logic [7:0] SACC_CHSEL_RST = 8'h00;
  localparam logic [3:0] SACC_PAIR_RST = 4'h0;
  localparam logic [3:0] SACC_TEMP_CODE = 4'h8;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SACC_TRACK_SAR_CLKS = 3;
  localparam int SACC_CONV_SAR_CLKS = 13;
  localparam int SACC_CORE_CLK_MHZ = 25;

  typedef enum logic [1:0] {
    SACC_SRC_SOFT,
    SACC_SRC_TMR3,
    SACC_SRC_EXT,
    SACC_SRC_TMR2
  } sacc_src_e;

  typedef enum logic [2:0] {
    SACC_G1,
    SACC_G2,
    SACC_G4,
    SACC_G8,
    SACC_G16,
    SACC_G0P5
  } sacc_gain_e;

  // analog side control bundle
  typedef struct packed {
    logic powered;
    logic tracking;
    logic converting;
    logic [3:0] channel;
    logic differential;
    sacc_gain_e gain;
  } sacc_analog_s;

endpackage

/* File: logic/sacc_top.sv */
// converter control: start sources, sequencing, result registers, AXI4-Lite slave
`timescale 1ns/1ps
// ----------------------------------------
// What this block does and what software must do
// [RL1] analog parts run only while enabled
// [RL2] nine channels, ninth is temperature sensor
// [RL3] pairs single-ended or differential, reset single-ended
// [RL4] gains 0.5 to 16 by field
// [RL5] reset gain is one
// [RL6] sar clock divides system clock
// [RL7] four start sources by select field
// [RL8] busy reads one during conversion
// [RL9] busy falling edge sets done flag
// [RL10] result justified into high/low bytes
// [RL11] software clears done, starts, polls
// [RL12] software routes external start pin first
// [RL13] normal mode tracks whenever idle
// [RL14] low-power mode tracks three sar clocks
// [RL15] external low-power: track while input low
// [RL16] chip standby stops tracking
// [RL17] software waits 1.5 us after changes
// [RL18] divider zero means undivided clock
// [RL19] gain field decode table
// [RL20] software clears done flag
// [RL21] right justify sign-extends high byte on differential channels
// [RL22] starts during conversion are ignored
// [RL23] external start synchronised before edges
// ----------------------------------------
module sacc_top
  import sacc_pkg::*;
#(
  parameter int DATA_BITS = 12
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic external_convert_start,
  input wire logic timer2_overflow,
  input wire logic timer3_overflow,
  input wire logic chip_standby,
  input wire logic [DATA_BITS-1:0] sar_sample,
  output sacc_analog_s analog_ctrl,
  output logic conversion_irq
);

  typedef enum logic [1:0] {SACC_IDLE, SACC_TRACK, SACC_CONV} sacc_state_e;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] converter_control_reg;
  logic [7:0] converter_config_reg;
  logic [7:0] channel_select_reg;
  logic [3:0] pair_config_reg;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  logic conversion_busy_bit;
  logic conversion_done_flag;
  sacc_state_e state_reg;
  logic [4:0] div_cnt_reg;
  logic [3:0] sar_cnt_reg;
  logic ext_sync1_reg, ext_sync2_reg, ext_prev_reg;
  logic busy_prev_reg;

  wire converter_enable_bit = converter_control_reg[SACC_CTRL_EN_BIT];
  wire low_power_track_select = converter_control_reg[SACC_CTRL_TM_BIT];
  wire [1:0] start_sel = converter_control_reg[SACC_CTRL_CM_LSB +: 2];
  wire justify_select = converter_control_reg[SACC_CTRL_LJ_BIT];
  wire [4:0] sar_clock_divider_field = converter_config_reg[SACC_CFG_DIV_LSB +: 5];
  wire [2:0] gain_select_field = converter_config_reg[SACC_CFG_GAIN_LSB +: 3];
  wire [3:0] channel_code_field = channel_select_reg[3:0];

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic aw_held_reg, w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire wr_ctrl = wr_fire && aw_addr_reg == SACC_CTRL_OFS;
  wire wr_done_clear = wr_ctrl && !w_data_reg[SACC_CTRL_DONE_BIT];
  wire soft_go = wr_ctrl && w_data_reg[SACC_CTRL_BUSY_BIT];
  wire rd_fire = s_axi_arvalid && s_axi_arready;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a[1:0] == 2'h0 && a <= SACC_SAMPLE_OFS;
  endfunction

  logic [7:0] rd_byte;
  always_comb begin
    unique case (s_axi_araddr)
      SACC_CTRL_OFS: rd_byte = {converter_control_reg[7:6], conversion_done_flag,
                                conversion_busy_bit, converter_control_reg[3:0]};
      SACC_CFG_OFS: rd_byte = converter_config_reg;
      SACC_CHSEL_OFS: rd_byte = channel_select_reg;
      SACC_PAIR_OFS: rd_byte = {4'h0, pair_config_reg};
      SACC_RESH_OFS: rd_byte = result_high_byte;
      SACC_RESL_OFS: rd_byte = result_low_byte;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_reg) ? 2'h0 : 2'h2;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // strobe lane 0 clear writes zero; reserved pair bits drop
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      converter_control_reg <= SACC_CTRL_RST;
      converter_config_reg <= SACC_CFG_RST; // see [RL5]
      channel_select_reg <= SACC_CHSEL_RST;
      pair_config_reg <= SACC_PAIR_RST; // see [RL3]
    end else if (clk_en && wr_fire) begin
      unique case (aw_addr_reg)
        SACC_CTRL_OFS: converter_control_reg <= w_data_reg;
        SACC_CFG_OFS: converter_config_reg <= w_data_reg;
        SACC_CHSEL_OFS: channel_select_reg <= {4'h0, w_data_reg[3:0]};
        SACC_PAIR_OFS: pair_config_reg <= w_data_reg[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // start sources
  // ----------------------------------------
  // only the second stage feeds the edge detector
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else if (clk_en) begin
      ext_sync1_reg <= external_convert_start; // see [RL23]
      ext_sync2_reg <= ext_sync1_reg;
      ext_prev_reg <= ext_sync2_reg;
    end
  end
  wire ext_rise = ext_sync2_reg && !ext_prev_reg; // see [RL23]

  logic start_evt;
  always_comb begin
    unique case (sacc_src_e'(start_sel)) // see [RL7]
      SACC_SRC_SOFT: start_evt = soft_go;
      SACC_SRC_TMR3: start_evt = timer3_overflow;
      SACC_SRC_EXT: start_evt = ext_rise;
      SACC_SRC_TMR2: start_evt = timer2_overflow;
    endcase
  end
  wire ext_lp = low_power_track_select && start_sel == SACC_SRC_EXT;

  // ----------------------------------------
  // sar clock and sequencer
  // ----------------------------------------
  // tick period 2*(low four divider bits+1) core clocks; zero divider ticks every clock
  wire sar_tick = sar_clock_divider_field == 5'h00 ||
                  div_cnt_reg == {sar_clock_divider_field[3:0], 1'b1}; // see [RL6] [RL18]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 5'h00;
    end else if (clk_en) begin
      div_cnt_reg <= (sar_tick || state_reg == SACC_IDLE) ? 5'h00 : div_cnt_reg + 5'h01;
    end
  end

  // extra start events while busy are simply dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= SACC_IDLE;
      sar_cnt_reg <= 4'h0;
    end else if (clk_en) begin
      unique case (state_reg)
        SACC_IDLE: begin
          if (converter_enable_bit && start_evt) begin // see [RL1] [RL22]
            sar_cnt_reg <= 4'h0;
            state_reg <= (low_power_track_select && !ext_lp) ? SACC_TRACK : SACC_CONV;
          end
        end
        SACC_TRACK: begin
          if (sar_tick) begin
            sar_cnt_reg <= sar_cnt_reg + 4'h1;
            if (sar_cnt_reg == 4'(SACC_TRACK_SAR_CLKS - 1)) begin // see [RL14]
              sar_cnt_reg <= 4'h0;
              state_reg <= SACC_CONV;
            end
          end
        end
        SACC_CONV: begin
          if (sar_tick) begin
            sar_cnt_reg <= sar_cnt_reg + 4'h1;
            if (sar_cnt_reg == 4'(SACC_CONV_SAR_CLKS - 1)) begin
              state_reg <= SACC_IDLE;
            end
          end
        end
      endcase
      if (!converter_enable_bit) begin
        state_reg <= SACC_IDLE;
      end
    end
  end

  wire conv_end = state_reg == SACC_CONV && sar_tick &&
                  sar_cnt_reg == 4'(SACC_CONV_SAR_CLKS - 1);

  // ----------------------------------------
  // busy, done and result
  // ----------------------------------------
  wire diff_sel = channel_code_field < SACC_TEMP_CODE &&
                  pair_config_reg[channel_code_field[2:1]]; // see [RL3]
  wire [11:0] sample12 = sar_sample[DATA_BITS-1 -: 12];
  wire sign_ext = diff_sel && sample12[11]; // see [RL21]
  wire busy_fall = busy_prev_reg && !conversion_busy_bit;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conversion_busy_bit <= 1'b0;
      busy_prev_reg <= 1'b0;
      conversion_done_flag <= 1'b0;
      result_high_byte <= 8'h00;
      result_low_byte <= 8'h00;
      conversion_irq <= 1'b0;
    end else if (clk_en) begin
      conversion_busy_bit <= state_reg != SACC_IDLE && !conv_end; // see [RL8]
      busy_prev_reg <= conversion_busy_bit;
      // set outranks a clear written in the same cycle
      if (busy_fall) begin
        conversion_done_flag <= 1'b1; // see [RL9]
      end else if (wr_done_clear) begin
        conversion_done_flag <= 1'b0; // see [RL20]
      end
      conversion_irq <= busy_fall; // see [RL9]
      if (conv_end) begin
        if (justify_select) begin // see [RL10]
          result_high_byte <= sample12[11:4];
          result_low_byte <= {sample12[3:0], 4'h0};
        end else begin
          result_high_byte <= {{4{sign_ext}}, sample12[11:8]}; // see [RL21]
          result_low_byte <= sample12[7:0];
        end
      end
    end
  end

  // ----------------------------------------
  // analog control outputs
  // ----------------------------------------
  wire track_now = converter_enable_bit && !chip_standby && // see [RL16]
                   (ext_lp ? (state_reg == SACC_IDLE && !ext_sync2_reg) : // see [RL15]
                    low_power_track_select ? state_reg == SACC_TRACK : // see [RL14]
                    state_reg != SACC_CONV); // see [RL13]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      analog_ctrl <= '0;
    end else if (clk_en) begin
      analog_ctrl.powered <= converter_enable_bit; // see [RL1]
      analog_ctrl.tracking <= track_now;
      analog_ctrl.converting <= state_reg == SACC_CONV;
      analog_ctrl.channel <= channel_code_field; // see [RL2]
      analog_ctrl.differential <= diff_sel;
      analog_ctrl.gain <= gain_select_field[2] ? // see [RL4] [RL19]
                          (gain_select_field[1] ? SACC_G0P5 : SACC_G16) :
                          sacc_gain_e'(gain_select_field);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_fall;
    conversion_busy_bit && clk_en ##1 !conversion_busy_bit;
  endsequence

  chk_done_sets: assert property (@(posedge core_clk) disable iff (rst) // see [RL9]
    s_fall ##1 clk_en |=> conversion_done_flag)
    else $error("done flag not set after busy fall");
  chk_off_idle: assert property (@(posedge core_clk) disable iff (rst) // see [RL1]
    !converter_enable_bit && clk_en |=> state_reg == SACC_IDLE)
    else $error("sequencer active while disabled");
  chk_busy_conv: assert property (@(posedge core_clk) disable iff (rst) // see [RL8]
    state_reg == SACC_CONV && !conv_end && clk_en |=> conversion_busy_bit)
    else $error("busy low during conversion");
  chk_gain_reset: assert property (@(posedge core_clk) // see [RL5]
    $fell(rst) |-> converter_config_reg[2:0] == 3'h0)
    else $error("gain not unity after reset");
  chk_pair_reset: assert property (@(posedge core_clk) // see [RL3]
    $fell(rst) |-> pair_config_reg == 4'h0)
    else $error("pairs not single-ended after reset");
  chk_no_restart: assert property (@(posedge core_clk) disable iff (rst) // see [RL22]
    state_reg == SACC_CONV && sar_cnt_reg != 4'h0 && clk_en && !conv_end &&
    converter_enable_bit |=> state_reg == SACC_CONV && sar_cnt_reg != 4'h0)
    else $error("conversion restarted");
  chk_sync_edge: assert property (@(posedge core_clk) disable iff (rst) // see [RL23]
    ext_rise |-> $past(ext_sync1_reg) && !ext_prev_reg)
    else $error("edge not from synchronised input");
  chk_lp_track: assert property (@(posedge core_clk) disable iff (rst) // see [RL14]
    state_reg == SACC_IDLE && clk_en && converter_enable_bit && start_evt &&
    low_power_track_select && !ext_lp |=> state_reg == SACC_TRACK)
    else $error("low-power start skipped tracking");
  chk_rjust_sign: assert property (@(posedge core_clk) disable iff (rst) // see [RL21]
    conv_end && clk_en && !justify_select |=>
    result_high_byte[7:4] == {4{$past(sign_ext)}})
    else $error("sign extension wrong");
  chk_undivided: assert property (@(posedge core_clk) disable iff (rst) // see [RL18]
    sar_clock_divider_field == 5'h00 |-> sar_tick)
    else $error("zero divider not undivided");

endmodule

/* File: testbench/sacc_far_model.sv */
// far-side model: sar result source and timer overflow pulses
`timescale 1ns/1ps
module sacc_far_model
  import sacc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire sacc_analog_s analog_ctrl,
  input wire logic [11:0] sample_value,
  input wire logic fire_t2,
  input wire logic fire_t3,
  output logic [11:0] sar_sample,
  output logic timer2_overflow,
  output logic timer3_overflow
);
  // ----------------------------------------
  // result word and timer pulses
  // ----------------------------------------
  // outside a conversion the word flips every cycle, so a stale capture shows up
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sar_sample <= 12'h000;
      timer2_overflow <= 1'b0;
      timer3_overflow <= 1'b0;
    end else begin
      sar_sample <= analog_ctrl.converting ? sample_value : ~sar_sample;
      timer2_overflow <= fire_t2;
      timer3_overflow <= fire_t3;
    end
  end
endmodule

/* File: testbench/tb_sar_adc_conversion_control.sv */
// self-checking testbench for the converter control block
`timescale 1ns/1ps
module tb_sar_adc_conversion_control
  import sacc_pkg::*;
;
  logic core_clk = 0;
  logic rst = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic ext_start = 1, standby = 0, fire_t2 = 0, fire_t3 = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [11:0] sample = 0;
  wire awready, wready, bvalid, arready, rvalid, irq, t2, t3;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [11:0] sar;
  sacc_analog_s actl;
  int n_errors = 0, compares = 0, n_trk = 0, n_cnv = 0, n_irq = 0, i;
  logic [31:0] rd;
  logic [1:0] rr;
  sacc_gain_e gain_exp [8] = '{SACC_G1, SACC_G2, SACC_G4, SACC_G8,
                               SACC_G16, SACC_G16, SACC_G0P5, SACC_G0P5};

  always #20 core_clk = ~core_clk;

  sacc_top dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .external_convert_start(ext_start), .timer2_overflow(t2), .timer3_overflow(t3),
    .chip_standby(standby), .sar_sample(sar), .analog_ctrl(actl), .conversion_irq(irq));

  sacc_far_model far (.core_clk(core_clk), .rst(rst), .analog_ctrl(actl),
    .sample_value(sample), .fire_t2(fire_t2), .fire_t3(fire_t3), .sar_sample(sar),
    .timer2_overflow(t2), .timer3_overflow(t3));

  // ----------------------------------------
  // monitors and shared tasks
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (actl.tracking === 1'b1) n_trk++;
    if (actl.converting === 1'b1) n_cnv++;
    if (irq === 1'b1) n_irq++;
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ready and response are looked at on the falling edge: they are registered,
  // so that is the value the next rising edge samples, with no race
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    ah = 0;
    wh = 0;
    bh = 0;
    r = 2'b11;
    @(posedge core_clk);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= {24'h0, d};
    bready <= 1;
    for (int n = 0; n < 50 && !bh; n++) begin
      @(negedge core_clk);
      if (awready) ah = 1;
      if (wready) wh = 1;
      if (bvalid) bh = 1;
      if (bvalid) r = bresp;
      @(posedge core_clk);
      if (ah) awvalid <= 0;
      if (wh) wvalid <= 0;
      if (bh) bready <= 0;
    end
    // one more edge: the written register's registered outputs settle before a compare
    @(posedge core_clk);
    if (!bh) begin
      n_errors++;
      close_out();
    end
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    ah = 0;
    rh = 0;
    d = 0;
    r = 2'b11;
    @(posedge core_clk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    for (int n = 0; n < 50 && !rh; n++) begin
      @(negedge core_clk);
      if (arready) ah = 1;
      if (rvalid) rh = 1;
      if (rvalid) d = rdata;
      if (rvalid) r = rresp;
      @(posedge core_clk);
      if (ah) arvalid <= 0;
      if (rh) rready <= 0;
    end
    if (!rh) begin
      n_errors++;
      close_out();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a, rd, rr);
    check({rr, rd}, {2'b00, 24'h0, e});
  endtask

  task automatic wait_done();
    for (int n = 0; n < 60; n++) begin
      rd_reg(SACC_CTRL_OFS, rd, rr);
      if (rd[SACC_CTRL_DONE_BIT] === 1'b1) return;
    end
    n_errors++;
    close_out();
  endtask

  // done is cleared first because hardware never clears it
  task automatic soft_conv(input logic [7:0] c);
    wr(SACC_CTRL_OFS, c, rr);
    n_cnv = 0;
    n_irq = 0;
    wr(SACC_CTRL_OFS, c | 8'h10, rr);
    wait_done();
  endtask

  task automatic pulse(input logic use_t2);
    @(posedge core_clk);
    if (use_t2) fire_t2 <= 1;
    else fire_t3 <= 1;
    @(posedge core_clk);
    fire_t2 <= 0;
    fire_t3 <= 0;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    rchk(SACC_CTRL_OFS, 8'h00);
    rchk(SACC_CFG_OFS, 8'hf8);
    rchk(SACC_PAIR_OFS, 8'h00);
    rchk(SACC_RESH_OFS, 8'h00);
    rchk(SACC_SAMPLE_OFS, 8'h00);
    check(34'(actl.gain), 34'(SACC_G1));
    check(34'(actl.powered), 34'h0);
    rd_reg(8'h1c, rd, rr);
    check({rr, rd}, {2'b10, 32'h0});
    wr(8'h1c, 8'hff, rr);
    check(34'(rr), 34'h2);
    for (i = 0; i < 8; i++) begin
      wr(SACC_CFG_OFS, 8'(i), rr);
      check(34'(actl.gain), 34'(gain_exp[i]));
    end
    wr(SACC_CFG_OFS, 8'h00, rr);
    wr(SACC_CHSEL_OFS, 8'h08, rr);
    check(34'(actl.channel), 34'h8);
    wr(SACC_CHSEL_OFS, 8'h00, rr);
    // 40 clocks of 40 ns give the input time to settle after the change
    repeat (40) @(posedge core_clk);
    wr(SACC_CTRL_OFS, 8'h80, rr);
    check(34'({actl.powered, actl.tracking}), 34'h3);
    standby <= 1;
    repeat (3) @(posedge core_clk);
    check(34'(actl.tracking), 34'h0);
    standby <= 0;
    sample <= 12'ha5c;
    soft_conv(8'h80);
    rchk(SACC_RESH_OFS, 8'h0a);
    rchk(SACC_RESL_OFS, 8'h5c);
    check(34'(n_irq), 34'h1);
    check(34'(n_cnv), 34'd13);
    soft_conv(8'h81);
    rchk(SACC_RESH_OFS, 8'ha5);
    rchk(SACC_RESL_OFS, 8'hc0);
    wr(SACC_PAIR_OFS, 8'h01, rr);
    check(34'(actl.differential), 34'h1);
    sample <= 12'h85c;
    soft_conv(8'h80);
    rchk(SACC_RESH_OFS, 8'hf8);
    wr(SACC_PAIR_OFS, 8'h00, rr);
    wr(SACC_CTRL_OFS, 8'hc0, rr);
    n_trk = 0;
    soft_conv(8'hc0);
    check(34'(n_trk), 34'd3);
    check(34'(n_cnv), 34'd13);
    // divider 1: four clocks per sar tick, divider held at zero until the start
    wr(SACC_CFG_OFS, 8'h08, rr);
    wr(SACC_CTRL_OFS, 8'h80, rr);
    n_cnv = 0;
    n_irq = 0;
    wr(SACC_CTRL_OFS, 8'h90, rr);
    rd_reg(SACC_CTRL_OFS, rd, rr);
    check(34'(rd[SACC_CTRL_BUSY_BIT]), 34'h1);
    wr(SACC_CTRL_OFS, 8'h90, rr);
    wait_done();
    check(34'(n_irq), 34'h1);
    check(34'(n_cnv >= 49 && n_cnv <= 52), 34'h1);
    wr(SACC_CFG_OFS, 8'h00, rr);
    for (i = 0; i < 2; i++) begin
      wr(SACC_CTRL_OFS, (i == 0) ? 8'h84 : 8'h8c, rr);
      n_irq = 0;
      pulse(i == 0);
      repeat (30) @(posedge core_clk);
      check(34'(n_irq), 34'h0);
      pulse(i != 0);
      wait_done();
      check(34'(n_irq), 34'h1);
    end
    // pin is assumed routed and open-drain; bench drives its level directly
    wr(SACC_CTRL_OFS, 8'hc8, rr);
    repeat (4) @(posedge core_clk);
    check(34'(actl.tracking), 34'h0);
    n_irq = 0;
    ext_start <= 0;
    repeat (5) @(posedge core_clk);
    check(34'(actl.tracking), 34'h1);
    check(34'(n_irq), 34'h0);
    ext_start <= 1;
    wait_done();
    check(34'(n_irq), 34'h1);
    wr(SACC_CTRL_OFS, 8'h00, rr);
    check(34'({actl.powered, actl.tracking}), 34'h0);
    close_out();
  end
endmodule
